// ### logic/brg_pkg.sv
// Constants, register map and carrier types for the back-end reset and gain-load block
package brg_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ACC_W = 24;

  // Own registers at word offsets
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_GAIN_READ = 8'h0C;
  localparam logic [7:0] ADDR_SNAPSHOT = 8'h10;
  // Control word indices; byte address is four times the index
  localparam int unsigned IDX_COUNTER_RESET = 25;
  localparam int unsigned IDX_GAIN_LOAD = 26;
  localparam int unsigned IDX_CONFIG = 27;
  localparam logic [7:0] ADDR_COUNTER_RESET = 8'(IDX_COUNTER_RESET * 4);
  localparam logic [7:0] ADDR_GAIN_LOAD = 8'(IDX_GAIN_LOAD * 4);
  localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 4);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CRST = 0;
  localparam int unsigned IRQ_GAIN = 1;
  localparam int unsigned IRQ_OVF = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int unsigned CFG_GAIN_INHIBIT = 15;

  // Reset pulse widths in cycles
  localparam logic [3:0] BE_RST_CYCLES = 4'hA;
  localparam logic [3:0] FE_RST_CYCLES = 4'h2;

  localparam int unsigned CORDIC_STEPS = 16;
  localparam logic [4:0] CORDIC_LOAD = 5'h10;

  localparam logic [3:0] FIFO_FULL_DEPTH = 4'h8;
  localparam logic [3:0] FIFO_INT_LEVEL = 4'h4;
  localparam logic [2:0] FIFO_RD_RESET = 3'h7;
  localparam logic [2:0] FIFO_WR_RESET = 3'h0;

  localparam logic [7:0] SNAP_INTERVAL = 8'h40;
  localparam logic [2:0] SER_DIV_LOAD = 3'h3;
  localparam logic [4:0] SER_BITS = 5'h10;
  localparam logic [2:0] SER_WORDS = 3'h4;
  localparam logic [1:0] SER_SYNC_LEN = 2'h1;

  // Gain word fields
  localparam int unsigned GAIN_HI = 15;
  localparam int unsigned GAIN_LO = 5;
  localparam int unsigned EXP_HI = 15;
  localparam int unsigned EXP_LO = 12;
  localparam int unsigned MANT_HI = 11;
  localparam int unsigned MANT_LO = 5;
  localparam int unsigned ACC_GAIN_LO = 13;
  localparam logic [1:0] MANT_PREFIX = 2'h1;
  localparam logic signed [15:0] GAIN_ERR_LIMIT = 16'sh0400;

  typedef enum {BRG_CORDIC_IDLE, BRG_CORDIC_RUN} brg_cordic_state_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic [3:0] depth;
  } brg_fifo_stat_t;

  typedef struct packed {
    logic [3:0] exponent;
    logic [8:0] mantissa;
  } brg_gain_t;

endpackage : brg_pkg

// ### logic/brg_top.sv
// Back-end counter reset, output FIFO, snapshot, serial output and gain-load logic
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module brg_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_DATA,
  output logic SAMPLE_READY,
  input wire logic GAIN_ERR_VALID,
  input wire logic [15:0] GAIN_ERR,
  input wire logic SECOND_SYNC_INPUT,
  input wire logic FIFO_RD,
  output logic [15:0] FIFO_DATA,
  output logic FIFO_READY,
  output logic FIFO_INTERRUPT,
  output logic FIFO_EMPTY,
  output logic FIFO_FULL,
  output logic [3:0] FIFO_DEPTH,
  output logic SER_CLK,
  output logic SER_DATA,
  output logic SER_SYNC,
  output logic [3:0] GAIN_EXP,
  output logic [8:0] GAIN_MANT,
  output logic FRONT_END_RST,
  output logic BACK_END_RST
);

  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = p + 3'h1;
  endfunction : ptr_inc

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic [31:0] cfg;
  logic [2:0] irq_mask;
  logic [2:0] irq_status;
  logic [15:0] gain_word;
  logic gain_load_strobe;
  logic [3:0] be_cnt;
  logic [3:0] fe_cnt;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  wire wr_fire = aw_full && w_full && !S_AXI_BVALID;
  wire wr_crst = wr_fire && (aw_addr == brg_pkg::ADDR_COUNTER_RESET);
  wire wr_gain = wr_fire && (aw_addr == brg_pkg::ADDR_GAIN_LOAD);
  wire wr_cfg = wr_fire && (aw_addr == brg_pkg::ADDR_CONFIG);
  wire wr_mask = wr_fire && (aw_addr == brg_pkg::ADDR_IRQ_MASK);
  wire wr_irq = wr_fire && (aw_addr == brg_pkg::ADDR_IRQ_STATUS);
  wire wr_known = wr_crst || wr_gain || wr_cfg || wr_mask || wr_irq;
  wire rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  wire rd_snap = rd_fire && (S_AXI_ARADDR == brg_pkg::ADDR_SNAPSHOT);
  wire be_rst = (be_cnt != 4'h0);
  wire gain_inhibit = cfg[brg_pkg::CFG_GAIN_INHIBIT];

  assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign BACK_END_RST = be_rst;
  assign FRONT_END_RST = (fe_cnt != 4'h0);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= brg_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr <= S_AXI_AWADDR;
        aw_full <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        w_full <= 1'b1;
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? brg_pkg::RESP_OKAY : brg_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Data is ignored; any write reloads both pulse widths
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      be_cnt <= 4'h0;
      fe_cnt <= 4'h0;
    end else if (wr_crst) begin
      be_cnt <= brg_pkg::BE_RST_CYCLES;
      fe_cnt <= brg_pkg::FE_RST_CYCLES;
    end else begin
      be_cnt <= be_rst ? be_cnt - 4'h1 : 4'h0;
      fe_cnt <= (fe_cnt != 4'h0) ? fe_cnt - 4'h1 : 4'h0;
    end
  end

  // Strobe is registered so the loop sees exactly one load cycle per write
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gain_word <= 16'h0000;
      gain_load_strobe <= 1'b0;
      cfg <= brg_pkg::CFG_RESET;
      irq_mask <= brg_pkg::IRQ_MASK_RESET;
    end else begin
      gain_load_strobe <= wr_gain;
      if (wr_gain) begin
        gain_word <= w_data[15:0];
      end
      if (wr_cfg) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            cfg[b*8 +: 8] <= w_data[b*8 +: 8];
          end
        end
      end
      if (wr_mask && w_strb[0]) begin
        irq_mask <= w_data[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over a write-one-to-clear in the same cycle
  logic fifo_overflow;
  wire [2:0] irq_set = {fifo_overflow, gain_load_strobe, wr_crst};
  wire [2:0] irq_clr = (wr_irq && w_strb[0]) ? w_data[2:0] : 3'h0;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign IRQ = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Second sync pin: three stages, accepted once stages two and three agree
  logic [2:0] sync_pipe;
  logic sync_lvl;
  wire sync_stable = (sync_pipe[1] == sync_pipe[2]);
  wire sync_rise = sync_stable && sync_pipe[1] && !sync_lvl;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync_pipe <= 3'h0;
      sync_lvl <= 1'b0;
    end else begin
      sync_pipe <= {sync_pipe[1:0], SECOND_SYNC_INPUT};
      if (sync_stable) begin
        sync_lvl <= sync_pipe[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gain loop accumulator
  logic [23:0] acc;
  logic [23:0] next_acc;
  wire signed [15:0] err = GAIN_ERR;
  wire signed [15:0] err_lim = (err > brg_pkg::GAIN_ERR_LIMIT) ? brg_pkg::GAIN_ERR_LIMIT :
                               (err < -brg_pkg::GAIN_ERR_LIMIT) ? -brg_pkg::GAIN_ERR_LIMIT : err;
  wire [23:0] err_ext = {{8{err_lim[15]}}, err_lim};
  wire acc_clear = !gain_inhibit && (be_rst || sync_rise);
  wire [23:0] acc_load = {gain_word[brg_pkg::GAIN_HI:brg_pkg::GAIN_LO], 13'h0000};

  // Load takes priority over a clear landing in the same cycle
  always_comb begin
    next_acc = acc;
    if (gain_load_strobe) begin
      next_acc = acc_load;
    end else if (acc_clear) begin
      next_acc = 24'h00_0000;
    end else if (GAIN_ERR_VALID) begin
      next_acc = acc + err_ext;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      acc <= 24'h00_0000;
    end else begin
      acc <= next_acc;
    end
  end

  brg_pkg::brg_gain_t gain;
  // One driver for the whole struct; fields are the exponent and the prefixed mantissa
  assign gain = '{exponent: acc[23:20], mantissa: {brg_pkg::MANT_PREFIX, acc[19:13]}};
  assign GAIN_EXP = gain.exponent;
  assign GAIN_MANT = gain.mantissa;

  ////////////////////////////////////////////////////////////////////////////////
  // Polar conversion sequencer
  brg_pkg::brg_cordic_state_t cstate;
  logic [4:0] cstep;
  logic [15:0] csample;
  wire cordic_done = (cstate == brg_pkg::BRG_CORDIC_RUN) && (cstep == 5'h01);
  wire [15:0] cordic_result = csample[15] ? 16'h0000 - csample : csample;

  assign SAMPLE_READY = (cstate == brg_pkg::BRG_CORDIC_IDLE) && !be_rst;

  always_ff @(posedge CLK) begin
    if (SYS_RST || be_rst) begin
      cstate <= brg_pkg::BRG_CORDIC_IDLE;
      cstep <= 5'h00;
      csample <= 16'h0000;
    end else begin
      case (cstate)
        brg_pkg::BRG_CORDIC_IDLE: begin
          if (SAMPLE_VALID) begin
            csample <= SAMPLE_DATA;
            cstep <= brg_pkg::CORDIC_LOAD;
            cstate <= brg_pkg::BRG_CORDIC_RUN;
          end
        end
        brg_pkg::BRG_CORDIC_RUN: begin
          cstep <= cstep - 5'h01;
          if (cordic_done) begin
            cstate <= brg_pkg::BRG_CORDIC_IDLE;
          end
        end
        default: cstate <= brg_pkg::BRG_CORDIC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output FIFO; read pointer names the last word read
  logic [15:0] fifo_mem [8];
  logic [2:0] rd_ptr;
  logic [2:0] wr_ptr;
  brg_pkg::brg_fifo_stat_t fstat;
  wire push = cordic_done && !fstat.full;
  wire pop = FIFO_RD && !fstat.empty;
  wire [3:0] next_depth = fstat.depth + {3'h0, push} - {3'h0, pop};

  assign fifo_overflow = cordic_done && fstat.full;
  assign FIFO_EMPTY = fstat.empty;
  assign FIFO_FULL = fstat.full;
  assign FIFO_DEPTH = fstat.depth;
  assign FIFO_READY = !fstat.empty;
  assign FIFO_INTERRUPT = (fstat.depth >= brg_pkg::FIFO_INT_LEVEL);

  always_ff @(posedge CLK) begin
    if (SYS_RST || be_rst) begin
      rd_ptr <= brg_pkg::FIFO_RD_RESET;
      wr_ptr <= brg_pkg::FIFO_WR_RESET;
      fstat <= '{full: 1'b0, empty: 1'b1, depth: 4'h0};
      FIFO_DATA <= 16'h0000;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr] <= cordic_result;
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        FIFO_DATA <= fifo_mem[ptr_inc(rd_ptr)];
        rd_ptr <= ptr_inc(rd_ptr);
      end
      fstat.depth <= next_depth;
      fstat.empty <= (next_depth == 4'h0);
      fstat.full <= (next_depth == brg_pkg::FIFO_FULL_DEPTH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Snapshot capture, read back through its own register
  logic [15:0] snap_mem [8];
  logic [2:0] snap_wr;
  logic [2:0] snap_rd;
  logic [2:0] snap_group;
  logic [7:0] snap_interval;
  wire snap_take = (snap_interval == 8'h00);

  always_ff @(posedge CLK) begin
    if (SYS_RST || be_rst) begin
      snap_group <= 3'h0;
      snap_interval <= brg_pkg::SNAP_INTERVAL;
      snap_wr <= 3'h0;
      snap_rd <= 3'h0;
    end else begin
      snap_interval <= snap_take ? brg_pkg::SNAP_INTERVAL : snap_interval - 8'h01;
      if (snap_take) begin
        snap_mem[snap_wr] <= cordic_result;
        snap_wr <= ptr_inc(snap_wr);
        snap_group <= snap_group + 3'h1;
      end
      if (rd_snap && (snap_rd != snap_wr)) begin
        snap_rd <= ptr_inc(snap_rd);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output; a word finishing while busy is only kept in the FIFO
  logic [2:0] ser_div;
  logic [4:0] ser_bits;
  logic [2:0] ser_words;
  logic [1:0] ser_sync_cnt;
  logic [15:0] ser_shift;
  logic ser_busy;
  wire ser_tick = (ser_div == 3'h0);

  always_ff @(posedge CLK) begin
    if (SYS_RST || be_rst) begin
      ser_div <= brg_pkg::SER_DIV_LOAD;
      ser_bits <= brg_pkg::SER_BITS;
      ser_words <= brg_pkg::SER_WORDS;
      ser_sync_cnt <= 2'h0;
      ser_shift <= 16'h0000;
      ser_busy <= 1'b0;
      SER_CLK <= 1'b0;
      SER_DATA <= 1'b0;
      SER_SYNC <= 1'b0;
    end else begin
      ser_div <= ser_tick ? brg_pkg::SER_DIV_LOAD : ser_div - 3'h1;
      SER_CLK <= ser_busy && (ser_div < 3'h2);
      if (!ser_busy && cordic_done) begin
        ser_shift <= cordic_result;
        ser_busy <= 1'b1;
        ser_bits <= brg_pkg::SER_BITS;
        ser_sync_cnt <= (ser_words == brg_pkg::SER_WORDS) ? brg_pkg::SER_SYNC_LEN : 2'h0;
      end else if (ser_busy && ser_tick) begin
        SER_DATA <= ser_shift[15];
        SER_SYNC <= (ser_sync_cnt != 2'h0);
        ser_sync_cnt <= (ser_sync_cnt != 2'h0) ? ser_sync_cnt - 2'h1 : 2'h0;
        ser_shift <= {ser_shift[14:0], 1'b0};
        ser_bits <= ser_bits - 5'h01;
        if (ser_bits == 5'h01) begin
          ser_busy <= 1'b0;
          ser_words <= (ser_words == 3'h1) ? brg_pkg::SER_WORDS : ser_words - 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = brg_pkg::RESP_OKAY;
    if (S_AXI_ARADDR == brg_pkg::ADDR_IRQ_STATUS) begin
      next_rdata = {29'h0000_0000, irq_status};
    end else if (S_AXI_ARADDR == brg_pkg::ADDR_IRQ_MASK) begin
      next_rdata = {29'h0000_0000, irq_mask};
    end else if (S_AXI_ARADDR == brg_pkg::ADDR_STATUS) begin
      next_rdata = {20'h0_0000, snap_group, (cstate == brg_pkg::BRG_CORDIC_RUN), be_rst, 1'b0,
                    fstat};
    end else if (S_AXI_ARADDR == brg_pkg::ADDR_GAIN_READ) begin
      next_rdata = {8'h00, acc};
    end else if (S_AXI_ARADDR == brg_pkg::ADDR_SNAPSHOT) begin
      next_rdata = {16'h0000, snap_mem[snap_rd]};
    end else if (S_AXI_ARADDR == brg_pkg::ADDR_CONFIG) begin
      next_rdata = cfg;
    end else begin
      next_rresp = brg_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= brg_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  AST_BE_RST_HOLD: assert property (wr_crst |=> be_rst [*8] ##1 be_rst ##1 be_rst)
    else $error("back-end reset shorter than ten cycles");
  AST_BE_RST_END: assert property (
    wr_crst ##1 (!wr_crst) [*8] ##1 !wr_crst |=> ##1 !be_rst)
    else $error("back-end reset longer than ten cycles");
  AST_FE_RST: assert property (wr_crst |=> FRONT_END_RST ##1 FRONT_END_RST)
    else $error("front-end reset missing");
  AST_CORDIC_ABORT: assert property (be_rst |=> cstate == brg_pkg::BRG_CORDIC_IDLE)
    else $error("conversion not aborted by reset");
  AST_FIFO_FLAGS: assert property (
    be_rst |=> FIFO_EMPTY && !FIFO_FULL && FIFO_DEPTH == 4'h0 && !FIFO_READY && !FIFO_INTERRUPT)
    else $error("FIFO flags wrong after reset");
  AST_FIFO_PTRS: assert property (
    be_rst |=> rd_ptr == brg_pkg::FIFO_RD_RESET && wr_ptr == brg_pkg::FIFO_WR_RESET)
    else $error("FIFO pointers wrong after reset");
  AST_SNAP: assert property (
    be_rst |=> snap_group == 3'h0 && snap_interval == brg_pkg::SNAP_INTERVAL && snap_wr == 3'h0)
    else $error("snapshot not reset");
  AST_SER: assert property (
    be_rst |=> ser_bits == brg_pkg::SER_BITS && ser_words == brg_pkg::SER_WORDS && !ser_busy)
    else $error("serial counters not reloaded");
  AST_STROBE: assert property (wr_gain |=> gain_load_strobe ##1 !gain_load_strobe)
    else $error("gain strobe not a single pulse");
  // The held word cannot change here: a new write needs the response to be gone first
  AST_GAIN_LOAD: assert property (
    gain_load_strobe |=> GAIN_EXP == gain_word[15:12] && GAIN_MANT[6:0] == gain_word[11:5]
    && acc[12:0] == 13'h0000)
    else $error("gain value not loaded into accumulator top bits");
  AST_MANT_PREFIX: assert property (GAIN_MANT[8:7] == brg_pkg::MANT_PREFIX)
    else $error("mantissa prefix wrong");
  AST_GAIN_CLEAR: assert property (
    (be_rst && !gain_inhibit && !gain_load_strobe) |=> acc == 24'h00_0000)
    else $error("accumulator not cleared");
  AST_GAIN_KEEP: assert property (
    (be_rst && gain_inhibit && !gain_load_strobe && !GAIN_ERR_VALID) |=> acc == $past(acc))
    else $error("accumulator cleared while inhibited");

  COV_CRST: cover property (wr_crst ##[1:12] !be_rst);
  COV_GAIN: cover property (gain_load_strobe);
  COV_FULL: cover property (FIFO_FULL);
  COV_SYNC: cover property (sync_rise && !gain_inhibit);

endmodule : brg_top

// ### verification/brg_far_end.sv
// Far-side model: sample source feeding the converter and reader of the output FIFO
`timescale 1ns/100ps
module brg_far_end (
  input wire logic clk,
  input wire logic send,
  input wire logic [15:0] value,
  input wire logic pop,
  input wire logic sample_ready,
  input wire logic [15:0] fifo_data,
  output logic sample_valid,
  output logic [15:0] sample_data,
  output logic fifo_rd,
  output logic [15:0] popped
);
  logic rd_d;
  initial begin
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    fifo_rd = 1'b0;
    rd_d = 1'b0;
    popped = 16'h0000;
  end
  always @(posedge clk) begin
    if (send) begin
      sample_valid <= 1'b1;
      sample_data <= value;
    end else if (sample_valid && sample_ready) begin
      sample_valid <= 1'b0;
      // Released bus shows the inverse, so a late capture cannot pass by luck
      sample_data <= ~sample_data;
    end
    fifo_rd <= pop;
    rd_d <= fifo_rd;
    // Word appears the cycle after the pop
    if (rd_d) begin
      popped <= fifo_data;
    end
  end
endmodule : brg_far_end

// ### verification/tb_top.sv
// Self-checking bench for the back-end reset and gain-load block
`timescale 1ns/100ps
module tb_top;
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic gerr_valid = 1'b0, sync_in = 1'b0, send = 1'b0, pop = 1'b0;
  logic [15:0] gerr = 16'h0000, value = 16'h0000, sample_data, fifo_data, popped;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq, sample_valid, sample_ready, fifo_rd;
  logic fifo_ready, fifo_int, fifo_empty, fifo_full, fe_rst, be_rst, ser_sync;
  logic [3:0] fifo_depth, gain_exp;
  logic [8:0] gain_mant;
  int bad_count = 0, checks_done = 0, be_n = 0, fe_n = 0, sync_n = 0;

  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    if (be_rst === 1'b1) be_n++;
    if (fe_rst === 1'b1) fe_n++;
    if (ser_sync === 1'b1) sync_n++;
  end

  brg_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq), .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data),
    .SAMPLE_READY(sample_ready), .GAIN_ERR_VALID(gerr_valid), .GAIN_ERR(gerr),
    .SECOND_SYNC_INPUT(sync_in), .FIFO_RD(fifo_rd), .FIFO_DATA(fifo_data),
    .FIFO_READY(fifo_ready), .FIFO_INTERRUPT(fifo_int), .FIFO_EMPTY(fifo_empty),
    .FIFO_FULL(fifo_full), .FIFO_DEPTH(fifo_depth), .SER_CLK(), .SER_DATA(), .SER_SYNC(ser_sync),
    .GAIN_EXP(gain_exp), .GAIN_MANT(gain_mant), .FRONT_END_RST(fe_rst),
    .BACK_END_RST(be_rst));

  brg_far_end far (.clk(CLK), .send(send), .value(value), .pop(pop),
    .sample_ready(sample_ready), .fifo_data(fifo_data), .sample_valid(sample_valid),
    .sample_data(sample_data), .fifo_rd(fifo_rd), .popped(popped));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask : chk

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLK);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdw

  task automatic sendp(input logic [15:0] v);
    @(posedge CLK);
    send <= 1'b1;
    value <= v;
    @(posedge CLK);
    send <= 1'b0;
    // Conversion takes 16 cycles before the push
    cyc(24);
  endtask : sendp

  task automatic popw;
    @(posedge CLK);
    pop <= 1'b1;
    @(posedge CLK);
    pop <= 1'b0;
    cyc(3);
  endtask : popw

  task wrap_up;
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    bad_count++;
    wrap_up();
  end

  initial begin
    cyc(8);
    SYS_RST <= 1'b0;
    cyc(1);
    chk("empty_at_reset", fifo_empty, 32'h1);
    chk("mant_at_reset", gain_mant, 32'h080);
    rdw(8'h20);
    chk("unmapped_resp", resp, brg_pkg::RESP_SLVERR);
    wr(brg_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    // Upper half and low five bits are junk on purpose
    wr(brg_pkg::ADDR_GAIN_LOAD, 32'hFFFF_ABFF);
    chk("gain_wr_resp", resp, brg_pkg::RESP_OKAY);
    // The accumulator takes the word one edge after the response shows
    cyc(1);
    chk("gain_exp", gain_exp, 32'hA);
    chk("gain_mant", gain_mant, 32'h0DF);
    chk("gain_irq", irq, 32'h1);
    rdw(brg_pkg::ADDR_GAIN_READ);
    chk("acc_loaded", rd, 32'h00AB_E000);
    @(posedge CLK);
    gerr <= 16'h0800;
    gerr_valid <= 1'b1;
    @(posedge CLK);
    gerr_valid <= 1'b0;
    cyc(3);
    rdw(brg_pkg::ADDR_GAIN_READ);
    chk("acc_limited", rd, 32'h00AB_E400);
    wr(brg_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    chk("irq_cleared", irq, 32'h0);
    sendp(16'h1234);
    sendp(16'hFFF0);
    sendp(16'h0005);
    sendp(16'h0006);
    chk("depth_four", fifo_depth, 32'h4);
    chk("fifo_int_set", fifo_int, 32'h1);
    popw();
    chk("first_pop", popped, 32'h1234);
    be_n = 0;
    fe_n = 0;
    sync_n = 0;
    wr(brg_pkg::ADDR_COUNTER_RESET, 32'h0000_DEAD);
    chk("ready_in_reset", sample_ready, 32'h0);
    cyc(14);
    chk("be_width", be_n, 32'd10);
    chk("fe_width", fe_n, 32'd2);
    chk("fifo_empty", fifo_empty, 32'h1);
    chk("fifo_full", fifo_full, 32'h0);
    chk("fifo_depth", fifo_depth, 32'h0);
    chk("fifo_ready", fifo_ready, 32'h0);
    chk("fifo_int", fifo_int, 32'h0);
    rdw(brg_pkg::ADDR_STATUS);
    chk("status_after", rd & 32'h0000_0FBF, 32'h0000_0010);
    rdw(brg_pkg::ADDR_GAIN_READ);
    chk("acc_cleared", rd, 32'h0);
    sendp(16'h0007);
    popw();
    chk("pointer_wrap", popped, 32'h0007);
    // Reloaded word counter puts the frame sync on the first word again
    chk("serial_sync", sync_n, 32'd4);
    @(posedge CLK);
    send <= 1'b1;
    value <= 16'h0009;
    @(posedge CLK);
    send <= 1'b0;
    // Reset lands while the conversion is still running
    wr(brg_pkg::ADDR_COUNTER_RESET, 32'h0000_0000);
    cyc(30);
    chk("aborted_conv", fifo_empty, 32'h1);
    wr(brg_pkg::ADDR_CONFIG, 32'h0000_8000);
    wr(brg_pkg::ADDR_GAIN_LOAD, 32'h0000_1000);
    wr(brg_pkg::ADDR_COUNTER_RESET, 32'h0000_0000);
    cyc(14);
    rdw(brg_pkg::ADDR_GAIN_READ);
    chk("acc_inhibited", rd, 32'h0010_0000);
    wr(brg_pkg::ADDR_CONFIG, 32'h0000_0000);
    @(posedge CLK);
    sync_in <= 1'b1;
    cyc(3);
    sync_in <= 1'b0;
    cyc(8);
    rdw(brg_pkg::ADDR_GAIN_READ);
    chk("acc_sync_clear", rd, 32'h0);
    wrap_up();
  end
endmodule : tb_top
